// [rtl/latch_loader_params.svh]
// Constants for the three-wire latch loader.
// Assumes inclusion by rtl files only; definitions only.
`ifndef LATCH_LOADER_PARAMS_SVH
`define LATCH_LOADER_PARAMS_SVH
`define WORD_BITS 24
`define CTRL_BITS 2
`define PD_BIT_POS 3
`define MUX_SEL_LSB 4
`define MUX_SEL_W 3
`define LATCH_RESET 24'h000000
`define MUX_SEL_LOCK 3'h0
`define MUX_SEL_RFDIV 3'h1
`define MUX_SEL_REFDIV 3'h2
`define FUNC_LATCH 2'h2
`endif

// [rtl/latch_loader_pkg.sv]
// Types shared by the latch loader files.
// Assumes the params header is on the include path.
package latch_loader_pkg;
   `include "latch_loader_params.svh"
   typedef struct packed {
      logic sclk;
      logic sdata;
      logic strobe;
   } serial_pins_type;
   typedef logic [`WORD_BITS-1:0] word_type;
endpackage

// [rtl/pin_sync.sv]
// Two-flop synchroniser for a bundle of pins.
// Assumes pins are asynchronous to sys_clk_i.
`timescale 1ns/1ns
module pin_sync #(
   parameter int WIDTH = 3
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   // Pins
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         stage1 <= '0;
         stage2 <= '0;
      end else begin
         stage1 <= async_i;
         stage2 <= stage1;
      end
   end
   assign sync_o = stage2;
endmodule

// [rtl/latch_loader.sv]
// Three-wire serial load port with four latches, power and monitor logic.
// Assumes serial pins are slow versus sys_clk_i (oversampled).
`timescale 1ns/1ns
`include "latch_loader_params.svh"
module latch_loader
   import latch_loader_pkg::*;
#(
   parameter int WORD_W = `WORD_BITS
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   // Serial pins and power enable pin
   input wire logic sclk_i,
   input wire logic sdata_i,
   input wire logic load_strobe_i,
   input wire logic power_enable_i,
   // Analog-side status
   input wire logic lock_detect_i,
   input wire logic rf_div_i,
   input wire logic ref_div_i,
   // Outputs
   output logic [WORD_W-1:0] latch0_o,
   output logic [WORD_W-1:0] latch1_o,
   output logic [WORD_W-1:0] latch2_o,
   output logic [WORD_W-1:0] latch3_o,
   output logic powered_o,
   output logic pump_output_oe_o,
   output logic monitor_output_o
);
   serial_pins_type pins_async, pins;
   logic pe_s1, pe;
   logic sclk_d, strobe_d;
   logic [WORD_W-1:0] shift, next_shift;
   logic [WORD_W-1:0] latches [4];
   logic [WORD_W-1:0] next_latches [4];
   logic next_monitor;
   logic next_powered;
   logic sclk_rise, strobe_rise;

   // Field decoders shared by the datapath and the checks
   function automatic logic [`CTRL_BITS-1:0] ctrl_field(
      input logic [WORD_W-1:0] w
   );
      return w[`CTRL_BITS-1:0];
   endfunction

   function automatic logic pd_field(input logic [WORD_W-1:0] w);
      return w[`PD_BIT_POS];
   endfunction

   function automatic logic [`MUX_SEL_W-1:0] mux_field(
      input logic [WORD_W-1:0] w
   );
      return w[`MUX_SEL_LSB +: `MUX_SEL_W];
   endfunction

   assign pins_async = '{sclk: sclk_i, sdata: sdata_i, strobe: load_strobe_i};

   pin_sync #(.WIDTH($bits(serial_pins_type))) u_sync (
      .sys_clk_i(sys_clk_i),
      .nrst_i(nrst_i),
      .async_i(pins_async),
      .sync_o(pins)
   );

   assign sclk_rise = pins.sclk & ~sclk_d;
   assign strobe_rise = pins.strobe & ~strobe_d;

   always_comb begin
      next_shift = shift;
      for (int i = 0; i < 4; i++) begin
         next_latches[i] = latches[i];
      end
      if (sclk_rise) begin
         next_shift = {shift[WORD_W-2:0], pins.sdata};
      end
      if (strobe_rise) begin
         next_latches[ctrl_field(shift)] = shift;
      end
   end

   // Monitor select lives in the function latch; unknown codes give low
   always_comb begin
      case (mux_field(latches[`FUNC_LATCH]))
         `MUX_SEL_LOCK: next_monitor = lock_detect_i;
         `MUX_SEL_RFDIV: next_monitor = rf_div_i;
         `MUX_SEL_REFDIV: next_monitor = ref_div_i;
         default: next_monitor = 1'b0;
      endcase
   end

   // Power needs the enable pin and a clear powerdown bit
   always_comb begin
      next_powered = pe & ~pd_field(latches[`FUNC_LATCH]);
   end

   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         pe_s1 <= 1'b0;
         pe <= 1'b0;
         sclk_d <= 1'b0;
         strobe_d <= 1'b0;
         shift <= `LATCH_RESET;
         for (int i = 0; i < 4; i++) begin
            latches[i] <= `LATCH_RESET;
         end
         monitor_output_o <= 1'b0;
         powered_o <= 1'b0;
      end else begin
         pe_s1 <= power_enable_i;
         pe <= pe_s1;
         sclk_d <= pins.sclk;
         strobe_d <= pins.strobe;
         shift <= next_shift;
         for (int i = 0; i < 4; i++) begin
            latches[i] <= next_latches[i];
         end
         monitor_output_o <= next_monitor;
         powered_o <= next_powered;
      end
   end

   // Pump drives only while powered; otherwise high impedance
   assign pump_output_oe_o = powered_o;
   assign latch0_o = latches[0];
   assign latch1_o = latches[1];
   assign latch2_o = latches[2];
   assign latch3_o = latches[3];

   property p_shift;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      sclk_rise |=> shift[0] == $past(pins.sdata);
   endproperty
   a_shift: assert property (p_shift) else $error("shift missed bit");

   property p_shift_hold;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      !sclk_rise |=> $stable(shift);
   endproperty
   a_shift_hold: assert property (p_shift_hold)
      else $error("shift moved");

   property p_load;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      strobe_rise |=> latches[ctrl_field($past(shift))] == $past(shift);
   endproperty
   a_load: assert property (p_load) else $error("latch not loaded");

   // Synchronised strobe low then high, then the latch its low bits pick
   sequence s_strobe_up;
      !pins.strobe ##1 pins.strobe;
   endsequence

   sequence s_word_taken;
      latches[ctrl_field($past(shift))] == $past(shift);
   endsequence

   property p_load_steps;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      s_strobe_up |=> s_word_taken;
   endproperty
   a_load_steps: assert property (p_load_steps)
      else $error("strobe edge lost");

   property p_latch_hold;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      !strobe_rise |=> $stable(latch0_o) && $stable(latch1_o)
         && $stable(latch2_o) && $stable(latch3_o);
   endproperty
   a_latch_hold: assert property (p_latch_hold)
      else $error("latch changed without strobe");

   property p_pd_low;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      !pe |=> !powered_o && !pump_output_oe_o;
   endproperty
   a_pd_low: assert property (p_pd_low) else $error("on while disabled");

   // The enable pin needs three edges to reach the power flop
   sequence s_enable_low;
      !power_enable_i [*3];
   endsequence

   sequence s_enable_high;
      power_enable_i [*3];
   endsequence

   property p_pd_pin;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      s_enable_low |=> !powered_o && !pump_output_oe_o;
   endproperty
   a_pd_pin: assert property (p_pd_pin)
      else $error("pin low but still powered");

   property p_pd_bit;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      pe |=> powered_o == !$past(pd_field(latches[`FUNC_LATCH]));
   endproperty
   a_pd_bit: assert property (p_pd_bit) else $error("power bit ignored");

   property p_pu_pin;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      s_enable_high |=>
         powered_o == !$past(pd_field(latches[`FUNC_LATCH]));
   endproperty
   a_pu_pin: assert property (p_pu_pin)
      else $error("pin high but power wrong");

   property p_mux;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      mux_field(latches[`FUNC_LATCH]) == `MUX_SEL_LOCK
         |=> monitor_output_o == $past(lock_detect_i);
   endproperty
   a_mux: assert property (p_mux) else $error("monitor wrong");

   property p_mux_rf;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      mux_field(latches[`FUNC_LATCH]) == `MUX_SEL_RFDIV
         |=> monitor_output_o == $past(rf_div_i);
   endproperty
   a_mux_rf: assert property (p_mux_rf)
      else $error("monitor not on divided rf");

   property p_mux_ref;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      mux_field(latches[`FUNC_LATCH]) == `MUX_SEL_REFDIV
         |=> monitor_output_o == $past(ref_div_i);
   endproperty
   a_mux_ref: assert property (p_mux_ref)
      else $error("monitor not on divided reference");

   // Unused select codes park the output low
   property p_mux_off;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      mux_field(latches[`FUNC_LATCH]) > `MUX_SEL_REFDIV
         |=> !monitor_output_o;
   endproperty
   a_mux_off: assert property (p_mux_off)
      else $error("monitor not parked low");
endmodule

// [verif/host_model.sv]
// Host model: drives the three-wire serial pins.
// Assumes a free-running sys_clk_i.
`timescale 1ns/1ns
module host_model (
   // Clock
   input wire logic sys_clk_i,
   // Serial pins
   output logic sclk_o,
   output logic sdata_o,
   output logic strobe_o
);
   initial begin
      sclk_o = 1'b0;
      sdata_o = 1'b0;
      strobe_o = 1'b0;
   end
   task automatic wait_n(input int n);
      repeat (n) @(posedge sys_clk_i);
      #2;
   endtask
   // Four cycles a level, so the synchroniser never drops an edge
   task automatic send(input logic [23:0] w);
      for (int i = 23; i >= 0; i--) begin
         sdata_o = w[i];
         wait_n(4);
         sclk_o = 1'b1;
         wait_n(4);
         sclk_o = 1'b0;
      end
      wait_n(4);
      strobe_o = 1'b1;
      wait_n(4);
      strobe_o = 1'b0;
   endtask
endmodule

// [verif/tb.sv]
// Testbench for latch_loader: latches, power and monitor.
// Assumes host_model drives the serial pins.
`timescale 1ns/1ns
module tb;
   import latch_loader_pkg::*;
   logic sys_clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic pwr_en = 1'b0;
   logic [2:0] src = 3'h0;
   logic sclk, sdata, strobe, powered, oe, mon;
   word_type lat [4];
   word_type exp_w [4];
   int n_fail = 0;
   int comparisons = 0;
   always #10 sys_clk_i = ~sys_clk_i;
   host_model HOST (.sys_clk_i(sys_clk_i), .sclk_o(sclk), .sdata_o(sdata),
      .strobe_o(strobe));
   latch_loader DUT (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .sclk_i(sclk),
      .sdata_i(sdata), .load_strobe_i(strobe), .power_enable_i(pwr_en),
      .lock_detect_i(src[0]), .rf_div_i(src[1]), .ref_div_i(src[2]),
      .latch0_o(lat[0]), .latch1_o(lat[1]), .latch2_o(lat[2]),
      .latch3_o(lat[3]), .powered_o(powered), .pump_output_oe_o(oe),
      .monitor_output_o(mon));
   task automatic check(input word_type seen, input word_type exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %0t got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic load(input word_type w);
      HOST.send(w);
      HOST.wait_n(6);
   endtask
   task automatic t_latches;
      for (int k = 0; k < 4; k++) begin
         exp_w[k] = {8'h5a ^ k[7:0], 14'h2b3c, k[1:0]};
         load(exp_w[k]);
      end
      // Checked after all loads so a misrouted word shows up
      for (int k = 0; k < 4; k++) begin
         check(lat[k], exp_w[k]);
      end
      $display("test latches done");
   endtask
   task automatic t_power;
      load(24'h000002);
      HOST.wait_n(6);
      check(powered, 1'b0);
      check(oe, 1'b0);
      pwr_en = 1'b1;
      HOST.wait_n(6);
      check(powered, 1'b1);
      check(oe, 1'b1);
      load(24'h00000a);
      check(powered, 1'b0);
      check(oe, 1'b0);
      load(24'h000002);
      check(powered, 1'b1);
      pwr_en = 1'b0;
      HOST.wait_n(6);
      check(powered, 1'b0);
      check(oe, 1'b0);
      pwr_en = 1'b1;
      $display("test power done");
   endtask
   task automatic t_monitor;
      // Code 3 is unused: every source high must still read low
      for (int s = 0; s < 4; s++) begin
         load({17'h0, s[2:0], 4'h2});
         for (int v = 0; v < 2; v++) begin
            src = (v[0] ? (3'h1 << s) : ~(3'h1 << s)) | {3{s == 3}};
            HOST.wait_n(4);
            check(mon, v[0] && s < 3);
         end
      end
      $display("test monitor done");
   endtask
   task automatic t_reset;
      nrst_i = 1'b0;
      HOST.wait_n(2);
      for (int k = 0; k < 4; k++) begin
         check(lat[k], 24'h000000);
      end
      check(powered, 1'b0);
      check(mon, 1'b0);
      nrst_i = 1'b1;
      HOST.wait_n(6);
      check(powered, 1'b1);
      $display("test reset done");
   endtask
   task automatic tally_and_finish;
      $display("fails %0d comparisons %0d", n_fail, comparisons);
      if (n_fail == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      HOST.wait_n(4);
      nrst_i = 1'b1;
      t_latches;
      t_power;
      t_reset;
      t_monitor;
      tally_and_finish;
   end
endmodule
